// *** hdl/tism_pkg.sv ***
package tism_pkg;
   localparam logic [7:0] ADDR_CONFIG      = 8'h40;
   localparam logic [7:0] ADDR_STATUS      = 8'h41;
   localparam logic [7:0] ADDR_MASK        = 8'h43;
   localparam logic [7:0] ADDR_STATUS_COPY = 8'h4c;
   // status bit positions
   localparam int BIT_LOCAL_ERR   = 0;
   localparam int BIT_REMOTE2_ERR = 1;
   localparam int BIT_DIODE2_FLT  = 2;
   localparam int BIT_AUX_INPUT   = 4;
   localparam int BIT_REMOTE1_ERR = 5;
   localparam int BIT_OVERHEAT    = 6;
   localparam int BIT_DIODE1_FLT  = 7;
   // configuration bit positions
   localparam int CFG_START       = 0;
   localparam int CFG_INT_ENABLE  = 1;
   localparam int CFG_INT_CLEAR   = 2;
   localparam int CFG_TRIP_LOCK   = 3;
   localparam int CFG_SOFT_RESET  = 4;
   localparam int CFG_FAN_OFF     = 5;
   localparam int CFG_AUX_FLIP    = 6;
   localparam int CFG_DIODE2_MODE = 7;
   localparam logic [7:0] CONFIG_RESET    = 8'h25;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [7:0] MASK_RESET      = 8'h00;
   localparam logic [7:0] MASK_WRITABLE   = 8'hf0;
   localparam logic [7:0] LATCHED_BITS    = 8'he7;
endpackage : tism_pkg

// *** hdl/tism_sticky_if.sv ***
`timescale 1ns/1ps
interface tism_sticky_if #(parameter int W = 8);
   logic [W-1:0] set;
   logic         clear;
   logic [W-1:0] value;
   modport owner (input set, input clear, output value);
   modport user  (output set, output clear, input value);
endinterface : tism_sticky_if

// *** hdl/tism_sticky.sv ***
`timescale 1ns/1ps
// bank of sticky event bits; a set arriving with the clear wins
module tism_sticky #(
   parameter int W = 8
) (
   input  wire logic          clk,
   input  wire logic          rst,
   tism_sticky_if.owner       sif
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sif.value <= '0;
      end else if (sif.clear) begin
         sif.value <= sif.set;
      end else begin
         sif.value <= sif.value | sif.set;
      end
   end
endmodule : tism_sticky

// *** hdl/tism_top.sv ***
`timescale 1ns/1ps
module tism_top (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       local_limit_error,
   input  wire logic       remote1_limit_error,
   input  wire logic       remote2_limit_error,
   input  wire logic       remote1_diode_fault,
   input  wire logic       remote2_diode_fault,
   input  wire logic       aux_input_pin,
   input  wire logic       overheat_line_n,
   output logic            irq_n_out,
   output logic            irq_n_oe
);
   logic [7:0] config_reg;
   logic [7:0] event_mask;
   logic [7:0] event_status;
   logic [7:0] raw_events;
   logic       aux_input_level;
   logic       overheat_line_seen;
   logic       soft_reset;
   logic       status_read;
   logic       irq_active;

   tism_sticky_if #(.W(8)) sif ();

   assign soft_reset = reg_wr && reg_addr == tism_pkg::ADDR_CONFIG
                       && reg_wdata[tism_pkg::CFG_SOFT_RESET];
   assign status_read = reg_rd && (reg_addr == tism_pkg::ADDR_STATUS
                        || reg_addr == tism_pkg::ADDR_STATUS_COPY);

   // level seen on the aux pin after optional inversion
   assign aux_input_level = aux_input_pin ^ config_reg[tism_pkg::CFG_AUX_FLIP];
   assign overheat_line_seen = ~overheat_line_n;

   always_comb begin
      raw_events = '0;
      raw_events[tism_pkg::BIT_LOCAL_ERR]   = local_limit_error;
      raw_events[tism_pkg::BIT_REMOTE2_ERR] = remote2_limit_error;
      raw_events[tism_pkg::BIT_DIODE2_FLT]  = remote2_diode_fault;
      raw_events[tism_pkg::BIT_REMOTE1_ERR] = remote1_limit_error;
      raw_events[tism_pkg::BIT_OVERHEAT]    = overheat_line_seen;
      raw_events[tism_pkg::BIT_DIODE1_FLT]  = remote1_diode_fault;
   end

   // latched error bits clear on a status read or soft reset;
   // an event present in that cycle is kept
   assign sif.set   = raw_events & tism_pkg::LATCHED_BITS;
   assign sif.clear = status_read || soft_reset;

   tism_sticky #(.W(8)) u_sticky (
      .clk (clk),
      .rst (rst),
      .sif (sif)
   );

   // aux bit is a live level, so reads cannot clear it
   always_comb begin
      event_status = sif.value & tism_pkg::LATCHED_BITS;
      event_status[tism_pkg::BIT_AUX_INPUT] = aux_input_level;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         config_reg <= tism_pkg::CONFIG_RESET;
      end else if (soft_reset) begin
         config_reg <= tism_pkg::CONFIG_RESET;
      end else if (reg_wr && reg_addr == tism_pkg::ADDR_CONFIG) begin
         config_reg <= reg_wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_mask <= tism_pkg::MASK_RESET;
      end else if (soft_reset) begin
         event_mask <= tism_pkg::MASK_RESET;
      end else if (reg_wr && reg_addr == tism_pkg::ADDR_MASK) begin
         event_mask <= reg_wdata & tism_pkg::MASK_WRITABLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            tism_pkg::ADDR_CONFIG:      reg_rdata <= config_reg;
            tism_pkg::ADDR_STATUS:      reg_rdata <= event_status;
            tism_pkg::ADDR_STATUS_COPY: reg_rdata <= event_status;
            tism_pkg::ADDR_MASK:        reg_rdata <= event_mask;
            default:                    reg_rdata <= '0;
         endcase
      end
   end

   assign irq_active = |(event_status & ~event_mask)
                       && !config_reg[tism_pkg::CFG_INT_CLEAR];
   // open-drain style: pulled low only while enabled and active
   assign irq_n_out = 1'h0;
   assign irq_n_oe  = irq_active && config_reg[tism_pkg::CFG_INT_ENABLE];

   // interrupt output gating
   a_mask_blocks: assert property (
      @(posedge clk) disable iff (rst)
      (event_status & ~event_mask) == '0 |-> !irq_n_oe)
      else $error("masked status drove interrupt");
   a_enable_gate: assert property (
      @(posedge clk) disable iff (rst)
      !config_reg[tism_pkg::CFG_INT_ENABLE] |-> !irq_n_oe)
      else $error("interrupt driven while disabled");
   a_clear_releases: assert property (
      @(posedge clk) disable iff (rst)
      config_reg[tism_pkg::CFG_INT_CLEAR] |-> !irq_n_oe)
      else $error("interrupt driven during clear");
   a_irq_asserts: assert property (
      @(posedge clk) disable iff (rst)
      (|(event_status & ~event_mask) && config_reg[tism_pkg::CFG_INT_ENABLE]
       && !config_reg[tism_pkg::CFG_INT_CLEAR]) |-> irq_n_oe)
      else $error("interrupt not driven");

   // every latched source shows up one cycle after it is seen, even when a
   // clearing read lands in the same cycle
   a_local_sets: assert property (
      @(posedge clk) disable iff (rst)
      local_limit_error |=> event_status[tism_pkg::BIT_LOCAL_ERR])
      else $error("local error not latched");
   a_local_held: assert property (
      @(posedge clk) disable iff (rst)
      local_limit_error ##1 !sif.clear |=> event_status[tism_pkg::BIT_LOCAL_ERR])
      else $error("local error dropped without a clear");
   a_remote2_sets: assert property (
      @(posedge clk) disable iff (rst)
      remote2_limit_error |=> event_status[tism_pkg::BIT_REMOTE2_ERR])
      else $error("remote two error not latched");
   a_diode2_sets: assert property (
      @(posedge clk) disable iff (rst)
      remote2_diode_fault |=> event_status[tism_pkg::BIT_DIODE2_FLT])
      else $error("diode two fault not latched");
   a_aux_follows: assert property (
      @(posedge clk) disable iff (rst)
      event_status[tism_pkg::BIT_AUX_INPUT]
         == (aux_input_pin ^ config_reg[tism_pkg::CFG_AUX_FLIP]))
      else $error("aux status not following pin");
   a_aux_read_kept: assert property (
      @(posedge clk) disable iff (rst)
      (status_read && event_status[tism_pkg::BIT_AUX_INPUT]) ##1
         ($stable(aux_input_pin) && $stable(config_reg[tism_pkg::CFG_AUX_FLIP]))
      |-> event_status[tism_pkg::BIT_AUX_INPUT])
      else $error("status read cleared the aux bit");
   a_remote1_sets: assert property (
      @(posedge clk) disable iff (rst)
      remote1_limit_error |=> event_status[tism_pkg::BIT_REMOTE1_ERR])
      else $error("remote one error not latched");
   a_overheat_sets: assert property (
      @(posedge clk) disable iff (rst)
      (!overheat_line_n && !soft_reset) |=> event_status[tism_pkg::BIT_OVERHEAT])
      else $error("overheat not latched");
   a_diode1_sets: assert property (
      @(posedge clk) disable iff (rst)
      remote1_diode_fault |=> event_status[tism_pkg::BIT_DIODE1_FLT])
      else $error("diode one fault not latched");
   a_clear_keeps: assert property (
      @(posedge clk) disable iff (rst)
      (config_reg[tism_pkg::CFG_INT_CLEAR] && !sif.clear)
      |=> ($past(event_status) & ~event_status & tism_pkg::LATCHED_BITS) == '0)
      else $error("interrupt clear changed latched status");

   // register side
   a_mask_write: assert property (
      @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == tism_pkg::ADDR_MASK)
      |=> event_mask == ($past(reg_wdata) & tism_pkg::MASK_WRITABLE))
      else $error("mask write not taken");
   a_mask_low_ro: assert property (
      @(posedge clk) disable iff (rst)
      (event_mask & ~tism_pkg::MASK_WRITABLE) == '0)
      else $error("read-only mask bits changed");
   a_mask_read: assert property (
      @(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == tism_pkg::ADDR_MASK)
      |=> reg_rdata == $past(event_mask))
      else $error("mask read returned wrong data");
   a_mirror_same: assert property (
      @(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == tism_pkg::ADDR_STATUS_COPY)
      |=> reg_rdata == $past(event_status))
      else $error("mirror read differs from status");
   a_soft_reset: assert property (
      @(posedge clk) disable iff (rst)
      soft_reset |=> (event_mask == tism_pkg::MASK_RESET
                      && config_reg == tism_pkg::CONFIG_RESET))
      else $error("soft reset did not restore defaults");
   a_soft_status: assert property (
      @(posedge clk) disable iff (rst)
      (soft_reset && raw_events == '0)
      |=> (event_status & tism_pkg::LATCHED_BITS) == tism_pkg::STATUS_RESET)
      else $error("soft reset left latched status");
   a_soft_self_clear: assert property (
      @(posedge clk) disable iff (rst)
      soft_reset |=> !config_reg[tism_pkg::CFG_SOFT_RESET])
      else $error("soft reset bit stayed set");
   a_enable_default: assert property (
      @(posedge clk) disable iff (rst)
      soft_reset |=> !config_reg[tism_pkg::CFG_INT_ENABLE])
      else $error("soft reset left interrupt enabled");
endmodule : tism_top

// *** testbench/tism_host.sv ***
`timescale 1ns/1ps
// host side of the register port; idle address and data show the inverse of the last value
module tism_host (
   input  wire logic       clk,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask : rd
endmodule : tism_host

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic       clk, rst, aux, flip, wr, rd, irq_n_out, irq_n_oe;
   logic [7:0] src, addr, wdata, rdata, got, ev;
   integer     fails, compares, seed, i;
   tism_host u_host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata));
   tism_top u_tism_top (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
      .reg_wdata(wdata), .reg_rdata(rdata), .local_limit_error(src[0]),
      .remote2_limit_error(src[1]), .remote2_diode_fault(src[2]), .aux_input_pin(aux),
      .remote1_limit_error(src[5]), .overheat_line_n(!src[6]), .remote1_diode_fault(src[7]),
      .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   // latched sources pass straight, bit 3 reads zero, bit 4 is the live pin xor flip
   function automatic logic [7:0] model(input logic [7:0] e, input logic a, input logic f);
      return (e & 8'he7) | {3'h0, a ^ f, 4'h0};
   endfunction : model
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      u_host.rd(a, got);
      chk(got, e);
   endtask : rchk
   task automatic pulse(input logic [7:0] e);
      @(posedge clk);
      src <= e;
      aux <= e[3];
      @(posedge clk);
      src <= 8'h00;
   endtask : pulse
   task automatic wrap_up;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   initial begin
      #(25 * 5000);
      fails++;
      wrap_up();
   end
   initial begin
      {fails, compares, seed} = {32'h0, 32'h0, 32'h0a22};
      {src, aux, flip, rst} = {8'h00, 3'h1};
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      rchk(tism_pkg::ADDR_MASK, 8'h00);
      rchk(tism_pkg::ADDR_STATUS_COPY, 8'h00);
      rchk(tism_pkg::ADDR_CONFIG, 8'h25);
      chk({7'h00, irq_n_oe}, 8'h00);
      $display("reset test done");
      for (i = 0; i < 28; i++) begin
         ev = (i < 8) ? 8'h01 << i : 8'($random(seed));
         pulse(ev);
         rchk(tism_pkg::ADDR_STATUS, model(ev, ev[3], flip));
         rchk(tism_pkg::ADDR_STATUS_COPY, model(8'h00, ev[3], flip));
      end
      // events still present at the clearing read must survive it
      @(posedge clk);
      src <= 8'ha3;
      fork
         rchk(tism_pkg::ADDR_STATUS, model(8'ha3, aux, flip));
         begin
            repeat (2) @(posedge clk);
            src <= 8'h00;
         end
      join
      rchk(tism_pkg::ADDR_STATUS, model(8'ha3, aux, flip));
      rchk(tism_pkg::ADDR_STATUS_COPY, model(8'h00, aux, flip));
      $display("event test done");
      pulse(8'h08);
      rchk(tism_pkg::ADDR_STATUS, 8'h10);
      rchk(tism_pkg::ADDR_STATUS, 8'h10);
      flip = 1'h1;
      u_host.wr(tism_pkg::ADDR_CONFIG, 8'h41);
      rchk(tism_pkg::ADDR_STATUS, model(8'h00, aux, flip));
      pulse(8'h00);
      rchk(tism_pkg::ADDR_STATUS, 8'h10);
      $display("aux test done");
      u_host.wr(tism_pkg::ADDR_CONFIG, 8'h43);
      #1 chk({7'h00, irq_n_oe}, 8'h01);
      chk({7'h00, irq_n_out}, 8'h00);
      u_host.wr(tism_pkg::ADDR_MASK, 8'hff);
      #1 chk({7'h00, irq_n_oe}, 8'h00);
      rchk(tism_pkg::ADDR_MASK, 8'hf0);
      u_host.wr(tism_pkg::ADDR_MASK, 8'h00);
      u_host.wr(tism_pkg::ADDR_CONFIG, 8'h47);
      #1 chk({7'h00, irq_n_oe}, 8'h00);
      rchk(tism_pkg::ADDR_STATUS, 8'h10);
      u_host.wr(tism_pkg::ADDR_MASK, 8'hf0);
      u_host.wr(tism_pkg::ADDR_CONFIG, 8'h10);
      flip = 1'h0;
      rchk(tism_pkg::ADDR_CONFIG, 8'h25);
      rchk(tism_pkg::ADDR_MASK, 8'h00);
      rchk(tism_pkg::ADDR_STATUS, 8'h00);
      $display("interrupt test done");
      // a reset in mid-run must drop a live interrupt and a written mask
      u_host.wr(tism_pkg::ADDR_MASK, 8'h80);
      u_host.wr(tism_pkg::ADDR_CONFIG, 8'h43);
      pulse(8'h40);
      #1 chk({7'h00, irq_n_oe}, 8'h01);
      @(posedge clk);
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rchk(tism_pkg::ADDR_MASK, 8'h00);
      rchk(tism_pkg::ADDR_STATUS_COPY, model(8'h00, aux, flip));
      chk({7'h00, irq_n_oe}, 8'h00);
      $display("second reset test done");
      wrap_up();
   end
endmodule : tb_top
